/* src/shpa_adapter.sv */
// Host port adapter between a programmed-I/O port space and a SASI bus
`timescale 1ns/10ps
// Operation
// - Read of port 1 returns status lines; bits 7..5 read zero.
// - Every bus status line is inverted so asserted reads as 1.
// - Status bit 4 is direction, 1 means controller to host.
// - Status bit 3 is command/data, 1 means command information.
// - Status bit 2 is message line.
// - Status bit 1 is controller busy.
// - Status bit 0 is controller request.
// - Read of port 0 returns the byte on the bus data lines.
// - Write of port 1 resets controller, clears ack and releases the data driver; ports 2,3 read, 3 write idle.
// - Write of port 2 generates a select pulse.
// - Outbound latch passes data while enabled, holds after enable falls.
// - Latch enable comes from a write to port 0.
// - Trailing edge of a port 0 write strobe sets the acknowledge flip-flop.
// - Data driver enabled only while direction line shows host to controller.
// - While request is inactive the acknowledge flip-flop stays cleared.
module shpa_adapter (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic [1:0] host_addr,
    input  wire logic       host_rd_n,
    input  wire logic       host_wr_n,
    input  wire logic [7:0] host_wdata,
    output logic [7:0]      host_rdata,
    input  wire logic [7:0] bus_data_n_in,
    output logic [7:0]      bus_data_n_out,
    output logic            bus_data_oe_n,
    input  wire logic       bus_req_n,
    input  wire logic       bus_busy_n,
    input  wire logic       bus_msg_n,
    input  wire logic       bus_cd_n,
    input  wire logic       bus_io_n,
    output logic            bus_ack_n,
    output logic            bus_sel_n,
    output logic            bus_rst_n
);
    import shpa_pkg::*;

    typedef enum logic [1:0] {
        SHPA_IDLE   = 2'b01,
        SHPA_STROBE = 2'b10
    } shpa_wr_t;

    // ------------------------------------------------------------
    // Port decode helper
    // ------------------------------------------------------------
    // One place for strobe-and-address matching, shared by read and write
    function automatic logic port_hit(input logic       act,
                                      input logic [1:0] port,
                                      input logic [1:0] want);
        return act && (port == want);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic [4:0] line_s1;
    logic [4:0] line_s2;
    logic       rd_s1;
    logic       rd_s2;
    logic [2:0] wr_s1;
    logic [2:0] wr_s2;
    logic [7:0] wd_s1;
    logic [7:0] wd_s2;

    // Two flops per pin; first stage read only by the second
    always_ff @(posedge core_clk) begin
        data_s1 <= bus_data_n_in;
        data_s2 <= data_s1;
        line_s1 <= {bus_io_n, bus_cd_n, bus_msg_n, bus_busy_n, bus_req_n};
        line_s2 <= line_s1;
        rd_s1   <= host_rd_n;
        rd_s2   <= rd_s1;
        wr_s1   <= {host_wr_n, host_addr};
        wr_s2   <= wr_s1;
        wd_s1   <= host_wdata;
        wd_s2   <= wd_s1;
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        rd_act     = ~rd_s2;
    wire        wr_act     = ~wr_s2[2];
    wire [1:0]  wr_port    = wr_s2[1:0];
    logic [1:0] rd_port_s1;
    logic [1:0] rd_port_s2;
    wire [4:0]  line_stat  = ~line_s2;
    wire        req_act    = line_stat[STAT_REQ_BIT];
    wire        dir_out    = ~line_stat[STAT_IO_BIT];
    wire [7:0]  stat_byte  = {3'b000, line_stat};
    wire        latch_en   = port_hit(wr_act, wr_port, OUTBOUND_BYTE_PORT);
    wire        rst_hit    = port_hit(wr_act, wr_port, RESET_STROBE_PORT);
    wire        sel_hit    = port_hit(wr_act, wr_port, SELECT_STROBE_PORT);
    logic       latch_en_q;
    wire        wr_trail   = latch_en_q && !wr_act;
    shpa_wr_t   wr_state;
    shpa_wr_t   next_wr_state;

    // Address sampled alongside the read strobe
    always_ff @(posedge core_clk) begin
        rd_port_s1 <= host_addr;
        rd_port_s2 <= rd_port_s1;
    end

    // Read mux; unused ports and idle cycles return zero so the host sees no junk
    wire       rd_data_hit = port_hit(rd_act, rd_port_s2, INBOUND_BYTE_PORT);
    wire       rd_stat_hit = port_hit(rd_act, rd_port_s2, LINE_STATE_PORT);
    wire [7:0] next_rdata  = rd_data_hit ? ~data_s2 :
                             rd_stat_hit ? stat_byte :
                             8'h00;

    // Strobe state: one pulse per write access
    always_comb begin
        case (wr_state)
            SHPA_IDLE:   next_wr_state = wr_act ? SHPA_STROBE : SHPA_IDLE;
            SHPA_STROBE: next_wr_state = wr_act ? SHPA_STROBE : SHPA_IDLE;
            default:     next_wr_state = SHPA_IDLE;
        endcase
    end
    wire first_wr = (wr_state == SHPA_IDLE) && wr_act;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] out_latch;
    logic       ack;

    // Next values for every registered bus output, kept as plain wires
    wire        ack_clr     = !req_act || rst_hit;
    wire        next_ack_n  = ~((ack || wr_trail) && req_act && !rst_hit);
    wire [7:0]  next_data_n = ~(latch_en ? wd_s2 : out_latch);
    wire        next_oe_n   = ~(dir_out && !rst_hit);
    wire        next_sel_n  = ~(sel_hit && first_wr);
    wire        next_rst_n  = ~(rst_hit && first_wr);

    // Write strobe tracking; one state step per clock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_state   <= SHPA_IDLE;
            latch_en_q <= 1'b0;
        end else begin
            wr_state   <= next_wr_state;
            latch_en_q <= latch_en;
        end
    end

    // Host read register; registered so the host sees a settled byte
    always_ff @(posedge core_clk) begin
        if (srst) begin
            host_rdata <= 8'h00;
        end else begin
            host_rdata <= next_rdata;
        end
    end

    // Latch modelled as a flop that follows while enabled, holds otherwise.
    // Trade-off: one clock of delay instead of a true level-sensitive latch.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            out_latch <= DATA_RESET;
        end else if (latch_en) begin
            out_latch <= wd_s2;
        end
    end

    // Acknowledge flop: clear beats set, so a dropping request always wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack <= ACK_RESET;
        end else if (ack_clr) begin
            ack <= 1'b0;
        end else if (wr_trail) begin
            ack <= 1'b1;
        end
    end

    // Bus side outputs; released and idle levels while in reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bus_ack_n      <= 1'b1;
            bus_data_n_out <= 8'hFF;
            bus_data_oe_n  <= 1'b1;
        end else begin
            bus_ack_n      <= next_ack_n;
            bus_data_n_out <= next_data_n;
            bus_data_oe_n  <= next_oe_n;
        end
    end

    // Strobes last one clock; a write held longer does not repeat them
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bus_sel_n <= 1'b1;
            bus_rst_n <= 1'b1;
        end else begin
            bus_sel_n <= next_sel_n;
            bus_rst_n <= next_rst_n;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ack_clear;
        @(posedge core_clk) disable iff (srst) !req_act |=> bus_ack_n;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack with request idle");

    property p_ack_set;
        @(posedge core_clk) disable iff (srst)
            (wr_trail && req_act && !rst_hit) |=> !bus_ack_n;
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("ack not set after write");

    property p_oe_dir;
        @(posedge core_clk) disable iff (srst) !dir_out |=> bus_data_oe_n;
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("driver on in input phase");

    property p_stat;
        @(posedge core_clk) disable iff (srst)
            (rd_act && rd_port_s2 == LINE_STATE_PORT) |=>
            host_rdata == {3'b000, ~$past(line_s2)};
    endproperty
    a_stat: assert property (p_stat) else $error("status byte wrong");

    property p_rdata;
        @(posedge core_clk) disable iff (srst)
            (rd_act && rd_port_s2 == INBOUND_BYTE_PORT) |=> host_rdata == ~$past(data_s2);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong");

    property p_sel;
        @(posedge core_clk) disable iff (srst) (sel_hit && first_wr) |=> !bus_sel_n ##1 bus_sel_n;
    endproperty
    a_sel: assert property (p_sel) else $error("select pulse wrong");

    property p_rst;
        @(posedge core_clk) disable iff (srst) (rst_hit && first_wr) |=> !bus_rst_n && bus_ack_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset strobe wrong");

    property p_hold;
        @(posedge core_clk) disable iff (srst) !latch_en |=> out_latch == $past(out_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch did not hold");

    property p_stat_top;
        @(posedge core_clk) disable iff (srst) rd_stat_hit |=> host_rdata[7:5] == 3'b000;
    endproperty
    a_stat_top: assert property (p_stat_top) else $error("unused status bits set");

    property p_stat_io;
        @(posedge core_clk) disable iff (srst)
            rd_stat_hit |=> host_rdata[STAT_IO_BIT] == !$past(bus_io_n, 3);
    endproperty
    a_stat_io: assert property (p_stat_io) else $error("direction bit wrong");

    property p_stat_cd;
        @(posedge core_clk) disable iff (srst)
            rd_stat_hit |=> host_rdata[STAT_CD_BIT] == !$past(bus_cd_n, 3);
    endproperty
    a_stat_cd: assert property (p_stat_cd) else $error("command bit wrong");

    property p_stat_msg;
        @(posedge core_clk) disable iff (srst)
            rd_stat_hit |=> host_rdata[STAT_MSG_BIT] == !$past(bus_msg_n, 3);
    endproperty
    a_stat_msg: assert property (p_stat_msg) else $error("message bit wrong");

    property p_stat_busy;
        @(posedge core_clk) disable iff (srst)
            rd_stat_hit |=> host_rdata[STAT_BUSY_BIT] == !$past(bus_busy_n, 3);
    endproperty
    a_stat_busy: assert property (p_stat_busy) else $error("busy bit wrong");

    property p_stat_req;
        @(posedge core_clk) disable iff (srst)
            rd_stat_hit |=> host_rdata[STAT_REQ_BIT] == !$past(bus_req_n, 3);
    endproperty
    a_stat_req: assert property (p_stat_req) else $error("request bit wrong");

    property p_data_pin;
        @(posedge core_clk) disable iff (srst)
            rd_data_hit |=> host_rdata == ~$past(bus_data_n_in, 3);
    endproperty
    a_data_pin: assert property (p_data_pin) else $error("read byte not from bus");

    property p_rd_idle;
        @(posedge core_clk) disable iff (srst) !(rd_data_hit || rd_stat_hit) |=> host_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle read not zero");

    property p_latch_pass;
        @(posedge core_clk) disable iff (srst) latch_en |=> out_latch == $past(wd_s2);
    endproperty
    a_latch_pass: assert property (p_latch_pass) else $error("latch did not pass");

    property p_drive_val;
        @(posedge core_clk) disable iff (srst)
            latch_en |=> bus_data_n_out == ~$past(wd_s2);
    endproperty
    a_drive_val: assert property (p_drive_val) else $error("driven byte wrong");

    property p_oe_on;
        @(posedge core_clk) disable iff (srst) (dir_out && !rst_hit) |=> !bus_data_oe_n;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver off in output phase");

    property p_rst_release;
        @(posedge core_clk) disable iff (srst) rst_hit |=> bus_data_oe_n && bus_ack_n && !ack;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("reset strobe left bus busy");

    property p_ack_stand;
        @(posedge core_clk) disable iff (srst) (!bus_ack_n && req_act && !rst_hit) |=> !bus_ack_n;
    endproperty
    a_ack_stand: assert property (p_ack_stand) else $error("ack dropped early");

    property p_req_sync;
        @(posedge core_clk) disable iff (srst) req_act == !$past(bus_req_n, 2);
    endproperty
    a_req_sync: assert property (p_req_sync) else $error("request not two stages");

    property p_sel_quiet;
        @(posedge core_clk) disable iff (srst) !(sel_hit && first_wr) |=> bus_sel_n;
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("stray select pulse");

    property p_rst_quiet;
        @(posedge core_clk) disable iff (srst) !(rst_hit && first_wr) |=> bus_rst_n;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("stray reset pulse");

    property p_state_hot;
        @(posedge core_clk) disable iff (srst) $onehot(wr_state);
    endproperty
    a_state_hot: assert property (p_state_hot) else $error("strobe state not one-hot");
endmodule

/* src/shpa_pkg.sv */
// Package of port offsets, status layout and opcodes for the host port adapter
package shpa_pkg;
    // ------------------------------------------------------------
    // Host port offsets
    // ------------------------------------------------------------
    localparam logic [1:0] INBOUND_BYTE_PORT   = 2'h0;
    localparam logic [1:0] LINE_STATE_PORT     = 2'h1;
    localparam logic [1:0] OUTBOUND_BYTE_PORT  = 2'h0;
    localparam logic [1:0] RESET_STROBE_PORT   = 2'h1;
    localparam logic [1:0] SELECT_STROBE_PORT  = 2'h2;
    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int STAT_REQ_BIT  = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_MSG_BIT  = 2;
    localparam int STAT_CD_BIT   = 3;
    localparam int STAT_IO_BIT   = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic       ACK_RESET  = 1'b0;
    // ------------------------------------------------------------
    // Controller opcodes used by host software
    // ------------------------------------------------------------
    localparam logic [7:0] TEST_UNIT_READY_OPCODE = 8'h00;
    localparam logic [7:0] RETURN_TO_ZERO_OPCODE  = 8'h01;
    localparam logic [7:0] SENSE_OPCODE           = 8'h03;
    localparam logic [7:0] FORMAT_OPCODE          = 8'h04;
    localparam logic [7:0] READ_OPCODE            = 8'h08;
    localparam logic [7:0] WRITE_OPCODE           = 8'h0A;
    localparam logic [7:0] SEEK_OPCODE            = 8'h0B;
    localparam logic [7:0] DRIVE_GEOMETRY_OPCODE  = 8'h0C;
    localparam logic [7:0] SELECT_CODE            = 8'h01;
    localparam int         COMMAND_BYTES          = 6;
endpackage

/* tb/shpa_ctrl_model.sv */
// Behavioural disk controller facing the host port adapter
`timescale 1ns/10ps
module shpa_ctrl_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] bus_data_n_in,
    input  wire logic       bus_ack_n,
    input  wire logic       bus_sel_n,
    input  wire logic       bus_rst_n,
    input  wire logic       frc_en,
    input  wire logic [4:0] frc_stat,
    input  wire logic [7:0] frc_data,
    input  wire logic       slow,
    output logic [7:0]      m_data_n,
    output logic            m_oe,
    output logic            bus_req_n,
    output logic            bus_busy_n,
    output logic            bus_msg_n,
    output logic            bus_cd_n,
    output logic            bus_io_n,
    output logic            got_stb,
    output logic [7:0]      got_byte,
    output int              sel_cnt,
    output int              rst_cnt
);
    logic req;
    logic busy;
    logic io;
    logic msg;
    logic [7:0] tx;
    // Forced mode lets the bench sweep any line pattern
    assign bus_req_n  = frc_en ? ~frc_stat[0] : ~req;
    assign bus_busy_n = frc_en ? ~frc_stat[1] : ~busy;
    assign bus_msg_n  = frc_en ? ~frc_stat[2] : ~msg;
    assign bus_cd_n   = frc_en ? ~frc_stat[3] : 1'b0;
    assign bus_io_n   = frc_en ? ~frc_stat[4] : ~io;
    assign m_oe       = frc_en ? frc_stat[4] : io;
    assign m_data_n   = frc_en ? ~frc_data : ~tx;
    always @(negedge bus_sel_n) sel_cnt++;
    always @(negedge bus_rst_n) rst_cnt++;
    // --------------------------------
    // Command phase, six bytes per selection
    // --------------------------------
    initial begin
        {req, busy, io, msg, tx, got_stb, got_byte, sel_cnt, rst_cnt} = '0;
        forever begin
            @(negedge bus_sel_n);
            @(posedge core_clk);
            #1 busy = 1'b1;
            repeat (6) begin
                repeat (slow ? 5 : 1) @(posedge core_clk);
                #1 req = 1'b1;
                wait (bus_ack_n === 1'b0);
                @(posedge core_clk);
                #1 got_byte = ~bus_data_n_in;
                got_stb = 1'b1;
                @(posedge core_clk);
                #1 got_stb = 1'b0;
                // Slow mode keeps ack standing a while
                repeat (slow ? 4 : 0) @(posedge core_clk);
                #1 req = 1'b0;
                wait (bus_ack_n === 1'b1);
            end
            // Completion: status byte then null byte, each under its own request
            #1 io = 1'b1;
            tx = frc_data;
            for (int s = 0; s < 2; s++) begin
                repeat (4) @(posedge core_clk);
                #1 req = 1'b1;
                repeat (24) @(posedge core_clk);
                #1 req = 1'b0;
                msg = 1'b1;
                tx = 8'h00;
            end
            repeat (4) @(posedge core_clk);
            #1 {io, msg, busy} = 3'b000;
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the host port adapter
`timescale 1ns/10ps
module tb_top;
    import shpa_pkg::*;
    logic       core_clk, srst, host_rd_n, host_wr_n, bus_data_oe_n, m_oe, rd_take;
    logic       bus_req_n, bus_busy_n, bus_msg_n, bus_cd_n, bus_io_n;
    logic       bus_ack_n, bus_sel_n, bus_rst_n, frc_en, slow, got_stb;
    logic [1:0] host_addr;
    logic [4:0] frc_stat;
    logic [7:0] host_wdata, host_rdata, bus_data_n_out, bus_data_n_in, m_data_n;
    logic [7:0] frc_data, got_byte;
    logic [7:0] exp_rd[$], exp_got[$];
    logic [7:0] ops[8] = '{TEST_UNIT_READY_OPCODE, RETURN_TO_ZERO_OPCODE, SENSE_OPCODE,
        FORMAT_OPCODE, READ_OPCODE, WRITE_OPCODE, SEEK_OPCODE, DRIVE_GEOMETRY_OPCODE};
    int         sel_cnt, rst_cnt, n_fail = 0, checks_done = 0;
    // Terminators pull released lines high
    assign bus_data_n_in = !bus_data_oe_n ? bus_data_n_out : (m_oe ? m_data_n : 8'hFF);
    shpa_adapter i_dut (.*);
    shpa_ctrl_model i_ctrl (.*);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // --------------------------------
    // Host port tasks
    // --------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 {host_addr, host_wdata, host_wr_n} = {a, d, 1'b0};
        repeat (3) @(posedge core_clk);
        #1 host_wr_n = 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        #1 {host_addr, host_rd_n} = {a, 1'b0};
        exp_rd.push_back(e);
        repeat (4) @(posedge core_clk);
        #1 rd_take = 1'b1;
        @(posedge core_clk);
        #1 {rd_take, host_rd_n} = 2'b01;
        repeat (3) @(posedge core_clk);
    endtask
    // Bounded wait for idle bus (m=1) or a fresh request (m=0)
    task automatic wt(input logic m);
        int n;
        for (n = 0; n < 300 && !(m ? bus_busy_n === 1'b1
                : (bus_req_n === 1'b0 && bus_ack_n === 1'b1)); n++) @(posedge core_clk);
        if (n == 300) chk(8'h00, 8'h01);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(negedge core_clk) begin
        if (rd_take) chk(host_rdata, exp_rd.pop_front());
        if (got_stb) chk(got_byte, exp_got.pop_front());
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        results();
    end
    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        logic [31:0] r;
        void'($urandom(32'h8648A0D9));
        {srst, host_rd_n, host_wr_n, host_addr, host_wdata, rd_take} = {3'b111, 11'h000};
        {frc_en, frc_stat, frc_data, slow} = {1'b1, 5'h10, 9'h000};
        repeat (3) @(posedge core_clk);
        #1 chk({7'h00, bus_ack_n}, 8'h01);
        chk({7'h00, bus_data_oe_n}, 8'h01);
        srst = 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            #1 {frc_stat, frc_data} = {r[4:0], r[15:8]};
            rd(2'h1, {3'b000, r[4:0]});
            chk({7'h00, bus_data_oe_n}, {7'h00, r[4]});
            if (r[4]) rd(2'h0, r[15:8]);
            rd(r[16] ? 2'h2 : 2'h3, 8'h00);
        end
        wr(2'h3, 8'hFF);
        chk(8'(sel_cnt + rst_cnt), 8'h00);
        r = $urandom;
        #1 frc_stat = 5'h01;
        wr(2'h0, r[7:0]);
        repeat (2) @(posedge core_clk);
        #1 host_wdata = r[15:8];
        chk({7'h00, bus_ack_n}, 8'h00);
        chk(bus_data_n_out, ~r[7:0]);
        wr(2'h1, r[15:8]);
        chk({7'h00, bus_ack_n}, 8'h01);
        chk(8'(rst_cnt), 8'h01);
        #1 frc_stat = 5'h00;
        wr(2'h0, r[23:16]);
        repeat (2) @(posedge core_clk);
        #1 host_wdata = r[31:24];
        chk({7'h00, bus_ack_n}, 8'h01);
        chk(bus_data_n_out, ~r[23:16]);
        frc_en = 1'b0;
        for (int k = 0; k < 8; k++) begin
            slow = k[0];
            wt(1'b1);
            frc_data = 8'($urandom);
            wr(2'h0, SELECT_CODE);
            wr(2'h2, SELECT_CODE);
            chk(8'(sel_cnt), 8'(k + 1));
            wt(1'b0);
            rd(2'h1, 8'h0B);
            for (int b = 0; b < COMMAND_BYTES; b++) begin
                r = $urandom;
                if (b == 0) r[7:0] = ops[k];
                wt(1'b0);
                exp_got.push_back(r[7:0]);
                wr(2'h0, r[7:0]);
                repeat (2) @(posedge core_clk);
            end
            wt(1'b0);
            rd(2'h1, 8'h1B);
            rd(2'h0, frc_data);
            for (int n = 0; n < 300 && bus_req_n !== 1'b1; n++) @(posedge core_clk);
            wt(1'b0);
            rd(2'h1, 8'h1F);
            rd(2'h0, 8'h00);
        end
        wt(1'b1);
        results();
    end
endmodule
